// *** bench/fcms_host_model.sv ***
/*
  fcms_host_model: AHB-Lite host that feeds configuration and pll words.
  Assumes one slave whose hreadyout comes back as i_hready.
*/
`timescale 1ns/100ps
module fcms_host_model
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   output logic      [31:0] o_haddr,
   output logic      [1:0]  o_htrans,
   output logic      [2:0]  o_hsize,
   output logic             o_hwrite,
   output logic      [31:0] o_hwdata
);
   initial
   begin
      o_haddr  = 32'h0000_0000;
      o_htrans = 2'h0;
      o_hsize  = 3'h2;
      o_hwrite = 1'b0;
      o_hwdata = 32'h0000_0000;
   end

   // one single word transfer; each phase is held until hready is seen high
   task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge i_ref_clk);
      o_haddr  <= {24'h00_0000, ofs};
      o_htrans <= 2'h2;
      o_hsize  <= 3'h2;
      o_hwrite <= wr;
      @(posedge i_ref_clk);
      while (i_hready !== 1'b1)
         @(posedge i_ref_clk);
      o_htrans <= 2'h0;
      o_hwdata <= wd;
      @(posedge i_ref_clk);
      while (i_hready !== 1'b1)
         @(posedge i_ref_clk);
      rd = i_hrdata;
      // stale data is flipped so nothing can lean on a lingering value
      o_hwdata <= ~wd;
   endtask : xfer
endmodule : fcms_host_model

// *** bench/testbench.sv ***
/*
  testbench: power-up delays, loading in every scheme, forced reload and
  pll reprogramming of fcms_sequencer. Assumes fcms_host_model as master.
*/
`timescale 1ns/100ps
module testbench
   import fcms_pkg::*;
;
   localparam int unsigned POR_L = 40;
   localparam int unsigned POR_S = 10;
   logic        i_ref_clk;
   logic        i_resetn;
   logic        por_sel, pull_n, chain_n, recfg_n, pll_pin;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hwrite, hreadyout, hresp;
   logic        chain_out_n, io_en, pull_en, reg_rst, user, cmd, dual, sdata, sen, upd;
   int          fails, compares;

   fcms_sequencer #(.P_POR_LONG_CYC(POR_L), .P_POR_SHORT_CYC(POR_S)) dut
   (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .i_por_delay_select(por_sel), .i_io_weak_pullup_select_n(pull_n),
      .i_chain_enable_in_n(chain_n), .i_reconfig_n(recfg_n),
      .i_pll_pin_data(pll_pin), .o_chain_enable_out_n(chain_out_n),
      .o_io_enable(io_en), .o_weak_pullup_en(pull_en), .o_reg_reset(reg_rst),
      .o_user_mode(user), .o_cmd_mode(cmd), .o_dual_pin_user(dual),
      .o_pll_scan_data(sdata), .o_pll_scan_en(sen), .o_pll_update(upd)
   );

   fcms_host_model host
   (
      .i_ref_clk(i_ref_clk), .i_hready(hreadyout), .i_hrdata(hrdata),
      .o_haddr(haddr), .o_htrans(htrans), .o_hsize(hsize), .o_hwrite(hwrite),
      .o_hwdata(hwdata)
   );

   initial
   begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   task automatic end_of_test;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic chk_b(input logic seen, input logic exp, input string msg);
      chk({31'h0000_0000, seen}, {31'h0000_0000, exp}, msg);
   endtask : chk_b

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      host.xfer(1'b1, ofs, d, rdat);
   endtask : wr

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask : cyc

   task automatic chk_state(input logic [2:0] st, input string msg);
      host.xfer(1'b0, OFS_STATUS, 32'h0000_0000, rdat);
      chk({29'h0000_0000, rdat[3:1]}, {29'h0000_0000, st}, msg);
      chk_b(hresp | ~hreadyout, 1'b0, "bus response not OKAY");
   endtask : chk_state

   task automatic t_power_up(input logic sel, input int early, input int late);
      @(posedge i_ref_clk);
      i_resetn <= 1'b0;
      por_sel  <= sel;
      chain_n  <= 1'b1;
      cyc(5);
      i_resetn <= 1'b1;
      @(negedge i_ref_clk);
      chk_b(cmd, 1'b1, "command mode at reset");
      chk_b(user | io_en, 1'b0, "user mode or io at reset");
      chk_b(chain_out_n, 1'b1, "chain out at reset");
      wr(OFS_DATA, 32'h0000_00A5);
      cyc(early);
      chk_state(3'h0, "delay not yet over");
      cyc(late);
      chk_state(3'h1, "delay over");
      chk({5'h00, rdat[31:5]}, 32'h0000_0000, "data taken during delay");
   endtask : t_power_up

   task automatic t_pullup;
      pull_n <= 1'b1;
      cyc(4);
      @(negedge i_ref_clk);
      chk_b(pull_en, 1'b0, "pull-ups off");
      @(posedge i_ref_clk);
      pull_n <= 1'b0;
      cyc(4);
      @(negedge i_ref_clk);
      chk_b(pull_en, 1'b1, "pull-ups on");
      chk_b(io_en, 1'b0, "io before load");
      wr(OFS_DATA, 32'h0000_005A);
      chk_state(3'h1, "waiting for chain in");
      chk({5'h00, rdat[31:5]}, 32'h0000_0000, "data with chain in high");
   endtask : t_pullup

   task automatic t_load(input logic [2:0] sch, input int n);
      int i;
      wr(OFS_CTRL, {29'h0000_0000, sch});
      wr(OFS_LEN, 32'h0000_0001);
      host.xfer(1'b0, OFS_LEN, 32'h0000_0000, rdat);
      chk(rdat, 32'h0000_0001, "length readback");
      host.xfer(1'b0, OFS_CTRL, 32'h0000_0000, rdat);
      chk(rdat, {29'h0000_0000, sch}, "scheme readback");
      chain_n <= 1'b0;
      cyc(4);
      for (i = 1; i < n; i++)
         wr(OFS_DATA, 32'h0000_00C3);
      chk_state(3'h2, "one unit short of length");
      wr(OFS_DATA, 32'h0000_00C3);
      i = 0;
      @(negedge i_ref_clk);
      while (reg_rst !== 1'b1 && i < 8)
      begin
         @(negedge i_ref_clk);
         i++;
      end
      chk_b(reg_rst & cmd & ~io_en, 1'b1, "register reset in command mode");
      i = 0;
      while (user !== 1'b1 && i < 8)
      begin
         @(negedge i_ref_clk);
         i++;
      end
      chk_b(user & ~cmd, 1'b1, "user mode alone");
      chk_b(io_en, 1'b1, "io enabled");
      chk_b(dual, 1'b1, "dual pins to user role");
      chk_b(chain_out_n | pull_en, 1'b0, "chain out and pull-ups");
   endtask : t_load

   task automatic t_reload;
      @(posedge i_ref_clk);
      recfg_n <= 1'b0;
      cyc(5);
      @(negedge i_ref_clk);
      chk_b(cmd & ~user & ~io_en, 1'b1, "forced back to command mode");
      @(posedge i_ref_clk);
      recfg_n <= 1'b1;
   endtask : t_reload

   task automatic t_pll(input logic src, input logic [15:0] w);
      int i;
      @(posedge i_ref_clk);
      pll_pin <= src;
      wr(OFS_PLL, {15'h0000, src, w});
      i = 0;
      @(negedge i_ref_clk);
      while (sen !== 1'b1 && i < 6)
      begin
         @(negedge i_ref_clk);
         i++;
      end
      for (i = 0; i < 16; i++)
      begin
         chk_b(sdata & sen, src | w[i], "pll bit");
         chk_b(upd, i == 15, "pll update");
         chk_b(user & ~cmd, 1'b1, "mode kept while shifting");
         @(negedge i_ref_clk);
      end
      chk_b(sen, 1'b0, "pll shift ended");
      host.xfer(1'b0, OFS_PLL_STAT, 32'h0000_0000, rdat);
      chk(rdat, 32'h0000_0000, "pll idle after shift");
   endtask : t_pll

   initial
   begin
      int              s;
      fcms_scheme_type sch;
      fails    = 0;
      compares = 0;
      i_resetn = 1'b0;
      por_sel  = 1'b0;
      pull_n   = 1'b0;
      chain_n  = 1'b1;
      recfg_n  = 1'b1;
      pll_pin  = 1'b0;
      t_power_up(1'b0, POR_L - 16, 20);
      t_power_up(1'b1, 1, 12);
      t_pullup;
      for (s = 0; s < 5; s++)
      begin
         sch = fcms_scheme_type'(s);
         if (s > 0)
            t_reload;
         t_load(sch, (sch == SCH_PASSIVE_SERIAL || sch == SCH_BOUNDARY_SCAN) ? 8 : 1);
      end
      wr(OFS_CTRL, 32'h0000_0005);
      host.xfer(1'b0, OFS_CTRL, 32'h0000_0000, rdat);
      chk(rdat, 32'h0000_0004, "unknown scheme refused");
      t_pll(1'b0, 16'hA5C3);
      t_pll(1'b1, 16'h0000);
      end_of_test;
   end

   // whole run is a few hundred cycles; this cuts a hang well beyond that
   initial
   begin
      #400_000;
      fails++;
      end_of_test;
   end
endmodule : testbench

// *** logic/fcms_sequencer.sv ***
/*
  fcms_sequencer: power-up delay, configuration load, initialization and
  user-mode sequencing, chain enable and serial pll counter reprogramming.
  Assumes an AHB-Lite master on i_ref_clk as the only slave of its bus
  segment, and pins from outside the clock domain.
*/
// Function
// - power-on delay is 100 ms with select low, 2 ms with select high.
// - user I/O held high impedance in power-up, before and during loading.
// - after loading, initialization resets registers, enables I/O, then runs logic; the code enables I/O in the same cycle as user mode.
// - loading plus initialization is command mode; afterwards user mode; exactly one.
// - a dedicated pin forces user mode back into reload, reinit and user mode.
// - weak pull-ups enabled before and during configuration only when select low.
// - chain-enable input gates loading; chain-enable output passes to next device.
// - five configuration schemes accepted.
// - byte per cycle in parallel schemes; load completes well under 100 ms.
// - pll counter settings shift serially from logic or from an I/O pin.
// - pll reprogramming leaves the rest of the device running in its mode.
// - after configuration, dual-purpose pins switch to their user role.
`timescale 1ns/100ps
module fcms_sequencer
   import fcms_pkg::*;
#(
   parameter int unsigned P_POR_LONG_CYC  = POR_LONG_CYC,
   parameter int unsigned P_POR_SHORT_CYC = POR_SHORT_CYC
)
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        i_por_delay_select,
   input  wire logic        i_io_weak_pullup_select_n,
   input  wire logic        i_chain_enable_in_n,
   input  wire logic        i_reconfig_n,
   input  wire logic        i_pll_pin_data,
   output logic             o_chain_enable_out_n,
   output logic             o_io_enable,
   output logic             o_weak_pullup_en,
   output logic             o_reg_reset,
   output logic             o_user_mode,
   output logic             o_cmd_mode,
   output logic             o_dual_pin_user,
   output logic             o_pll_scan_data,
   output logic             o_pll_scan_en,
   output logic             o_pll_update
);
   logic [NUM_PINS-1:0] sync1_r;
   logic [NUM_PINS-1:0] sync2_r;
   fcms_state_type      state_r;
   fcms_state_type      state_nxt;
   fcms_aphase_type     aph_r;
   logic [31:0]         por_cnt_r;
   logic [2:0]          init_cnt_r;
   logic [2:0]          scheme_r;
   logic [23:0]         len_r;
   logic [26:0]         bits_r;
   logic [PLL_BITS-1:0] pll_sh_r;
   logic [4:0]          pll_cnt_r;
   logic                pll_src_pin_r;

   // two-flop synchronisers for every pin; stage one is read only by stage two
   genvar g;
   for (g = 0; g < NUM_PINS; g++)
   begin : g_sync
      always_ff @(posedge i_ref_clk)
      begin
         if (!i_resetn)
         begin
            sync1_r[g] <= PIN_RST[g];
            sync2_r[g] <= PIN_RST[g];
         end
         else if (i_ce)
         begin
            sync1_r[g] <= (g == PIN_POR_DELAY_SELECT) ? i_por_delay_select :
                          (g == PIN_PULLN)  ? i_io_weak_pullup_select_n :
                          (g == PIN_CEN)    ? i_chain_enable_in_n :
                          (g == PIN_RECFGN) ? i_reconfig_n : i_pll_pin_data;
            sync2_r[g] <= sync1_r[g];
         end
      end
   end

   wire        por_sel_s   = sync2_r[PIN_POR_DELAY_SELECT];
   wire        pull_n_s    = sync2_r[PIN_PULLN];
   wire        ce_n_s      = sync2_r[PIN_CEN];
   wire        recfg_n_s   = sync2_r[PIN_RECFGN];
   wire        pll_pin_s   = sync2_r[PIN_PLLD];

   wire        aph_take    = hsel && htrans[1] && hready;
   wire        wr_data     = fcms_hit(aph_r, OFS_DATA) && aph_r.write;
   wire        wr_ctrl     = fcms_hit(aph_r, OFS_CTRL) && aph_r.write;
   wire        wr_len      = fcms_hit(aph_r, OFS_LEN) && aph_r.write;
   wire        wr_pll      = fcms_hit(aph_r, OFS_PLL) && aph_r.write;
   // serial schemes take one bit per write, parallel ones a byte
   wire        par_scheme  = (scheme_r == SCH_PARALLEL_ASYNC) ||
                             (scheme_r == SCH_FAST_PARALLEL) ||
                             (scheme_r == SCH_CFG_DEVICE);
   wire [26:0] bits_step   = par_scheme ? 27'h000_0008 : 27'h000_0001;
   wire        load_acc    = wr_data && (state_r == ST_LOAD) && !ce_n_s;
   wire [26:0] bits_sum    = bits_r + bits_step;
   wire        load_done   = load_acc && (bits_sum >= {len_r, 3'b000});
   wire [31:0] por_limit   = por_sel_s ? P_POR_SHORT_CYC : P_POR_LONG_CYC;
   wire        por_done    = (por_cnt_r >= por_limit - 32'h0000_0001);
   wire        pll_busy    = (pll_cnt_r != 5'h00);
   wire        pll_bit     = pll_src_pin_r ? pll_pin_s : pll_sh_r[0];
   wire        is_user     = (state_nxt == ST_USER);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_POR:     if (por_done) state_nxt = ST_WAIT_CE;
         ST_WAIT_CE: if (!ce_n_s) state_nxt = ST_LOAD;
         ST_LOAD:    if (load_done) state_nxt = ST_INIT;
         ST_INIT:    if (init_cnt_r == 3'(INIT_CYC - 1)) state_nxt = ST_USER;
         ST_USER:    if (!recfg_n_s) state_nxt = ST_WAIT_CE;
      endcase
      // forcing pin restarts loading from any command-mode step past the delay
      if (!recfg_n_s && (state_r != ST_POR))
         state_nxt = ST_WAIT_CE;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         state_r    <= ST_POR;
         por_cnt_r  <= 32'h0000_0000;
         init_cnt_r <= 3'h0;
         bits_r     <= 27'h000_0000;
      end
      else if (i_ce)
      begin
         state_r    <= state_nxt;
         por_cnt_r  <= (state_r == ST_POR) ? por_cnt_r + 32'h0000_0001 : por_cnt_r;
         init_cnt_r <= (state_r == ST_INIT) ? init_cnt_r + 3'h1 : 3'h0;
         if (state_nxt == ST_WAIT_CE)
            bits_r <= 27'h000_0000;
         else if (load_acc)
            bits_r <= bits_sum;
      end
   end

   // pin-facing outputs follow the next state so they line up with state_r
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_io_enable          <= 1'b0;
         o_weak_pullup_en     <= 1'b0;
         o_reg_reset          <= 1'b0;
         o_user_mode          <= 1'b0;
         o_cmd_mode           <= 1'b1;
         o_dual_pin_user      <= 1'b0;
         o_chain_enable_out_n <= 1'b1;
      end
      else if (i_ce)
      begin
         o_io_enable          <= is_user;
         o_weak_pullup_en     <= !is_user && !pull_n_s;
         o_reg_reset          <= (state_nxt == ST_INIT) && (state_r != ST_INIT);
         o_user_mode          <= is_user;
         o_cmd_mode           <= !is_user;
         o_dual_pin_user      <= is_user;
         o_chain_enable_out_n <= !((state_nxt == ST_INIT) || is_user);
      end
   end

   // bus slave: zero wait states, OKAY always, read data prepared in address phase
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         aph_r     <= '0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         scheme_r  <= CTRL_RST;
         len_r     <= LEN_RST;
      end
      else if (i_ce)
      begin
         aph_r.valid <= aph_take;
         aph_r.write <= hwrite;
         aph_r.addr  <= {haddr[7:2], 2'b00};
         if (aph_take && !hwrite)
            unique case ({haddr[7:2], 2'b00})
               OFS_CTRL:     hrdata <= {29'h0000_0000, scheme_r};
               OFS_LEN:      hrdata <= {8'h00, len_r};
               OFS_STATUS:   hrdata <= {bits_r, o_user_mode, state_r, ce_n_s};
               OFS_PLL:      hrdata <= {15'h0000, pll_src_pin_r, pll_sh_r};
               OFS_PLL_STAT: hrdata <= {26'h000_0000, pll_busy, pll_cnt_r};
               default:      hrdata <= 32'h0000_0000;
            endcase
         if (wr_ctrl && (hwdata[2:0] <= 3'(SCH_BOUNDARY_SCAN)))
            scheme_r <= hwdata[2:0];
         if (wr_len)
            len_r <= hwdata[23:0];
      end
   end

   // pll shift chain runs independently of the mode sequencer
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         pll_sh_r        <= '0;
         pll_cnt_r       <= 5'h00;
         pll_src_pin_r   <= 1'b0;
         o_pll_scan_data <= 1'b0;
         o_pll_scan_en   <= 1'b0;
         o_pll_update    <= 1'b0;
      end
      else if (i_ce)
      begin
         o_pll_update <= (pll_cnt_r == 5'h01);
         if (wr_pll && !pll_busy)
         begin
            pll_sh_r      <= hwdata[PLL_BITS-1:0];
            pll_src_pin_r <= hwdata[PLL_SRC_POS];
            pll_cnt_r     <= 5'(PLL_BITS);
         end
         else if (pll_busy)
         begin
            pll_sh_r  <= pll_sh_r >> 1;
            pll_cnt_r <= pll_cnt_r - 5'h01;
         end
         o_pll_scan_en   <= pll_busy;
         o_pll_scan_data <= pll_busy ? pll_bit : 1'b0;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   property p_por_gate;
      (state_r == ST_POR) |-> !load_acc && o_cmd_mode;
   endproperty
   a_por_gate: assert property (p_por_gate) else $error("load during power-on delay");
   property p_io_hiz;
      (state_r != ST_USER) && i_ce |=> (state_r == ST_USER) || !o_io_enable;
   endproperty
   a_io_hiz: assert property (p_io_hiz) else $error("io enabled in command mode");
   property p_load_init;
      load_done && i_ce && recfg_n_s |=> (state_r == ST_INIT) && o_reg_reset;
   endproperty
   a_load_init: assert property (p_load_init) else $error("no init after load");
   property p_modes;
      o_user_mode != o_cmd_mode;
   endproperty
   a_modes: assert property (p_modes) else $error("mode flags not exclusive");
   property p_force;
      (state_r == ST_USER) && !recfg_n_s && i_ce |=> !o_user_mode && (state_r == ST_WAIT_CE);
   endproperty
   a_force: assert property (p_force) else $error("forcing pin ignored");
   property p_pullup;
      i_ce && (state_r == ST_LOAD) && $stable(pull_n_s) |=> o_weak_pullup_en == !pull_n_s;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up state wrong");
   property p_chain;
      !o_chain_enable_out_n |-> (state_r == ST_INIT) || (state_r == ST_USER);
   endproperty
   a_chain: assert property (p_chain) else $error("chain out early");
   property p_pll_keep;
      o_user_mode && pll_busy && recfg_n_s && i_ce |=> o_user_mode;
   endproperty
   a_pll_keep: assert property (p_pll_keep) else $error("pll shift left user mode");
   property p_pll_len;
      wr_pll && !pll_busy && i_ce ##1 i_ce [*8] ##1 i_ce [*8] |=> o_pll_update;
   endproperty
   a_pll_len: assert property (p_pll_len) else $error("pll update timing");
   property p_dual;
      $rose(o_dual_pin_user) |-> $past(state_r == ST_INIT) && o_io_enable;
   endproperty
   a_dual: assert property (p_dual) else $error("dual pins switched early");
   // the short delay is the floor: no select setting may leave power-on sooner
   property p_por_min;
      (state_r == ST_POR) && i_ce && (por_cnt_r < P_POR_SHORT_CYC - 1) |=> (state_r == ST_POR);
   endproperty
   a_por_min: assert property (p_por_min) else $error("power-on delay cut short");
   // the fast parallel scheme must advance the loaded count by a whole byte per word
   property p_byte_step;
      load_acc && i_ce && recfg_n_s && (scheme_r == SCH_FAST_PARALLEL)
         |=> bits_r == $past(bits_r) + 27'h000_0008;
   endproperty
   a_byte_step: assert property (p_byte_step) else $error("parallel word not a byte");

   c_user:   cover property ((state_r == ST_INIT) ##1 (state_r == ST_USER));
   c_reload: cover property ((state_r == ST_USER) ##1 (state_r == ST_WAIT_CE));
   c_pll:    cover property (o_pll_update && o_user_mode);
   c_pullup: cover property (o_weak_pullup_en && (state_r == ST_LOAD));
   c_serial: cover property (load_done && !par_scheme);
endmodule : fcms_sequencer

// *** shared/fcms_pkg.sv ***
/*
  fcms_pkg: constants, register map, states and carriers for the
  configuration mode sequencer. Assumes a 25 MHz reference clock.
*/
package fcms_pkg;
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned POR_LONG_MS    = 100;
   localparam int unsigned POR_SHORT_MS   = 2;
   localparam int unsigned POR_LONG_CYC   = POR_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned POR_SHORT_CYC  = POR_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned INIT_CYC       = 4;
   localparam int unsigned PLL_BITS       = 16;
   localparam int unsigned NUM_PINS       = 5;

   // byte offsets of the register words
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_LEN      = 8'h04;
   localparam logic [7:0] OFS_DATA     = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0C;
   localparam logic [7:0] OFS_PLL      = 8'h10;
   localparam logic [7:0] OFS_PLL_STAT = 8'h14;

   localparam logic [2:0]  CTRL_RST   = 3'h0;
   localparam logic [23:0] LEN_RST    = 24'h00_0010;
   localparam int unsigned PLL_SRC_POS = 16;

   // pin index in the synchroniser vector
   localparam int unsigned PIN_POR_DELAY_SELECT = 0;
   localparam int unsigned PIN_PULLN  = 1;
   localparam int unsigned PIN_CEN    = 2;
   localparam int unsigned PIN_RECFGN = 3;
   localparam int unsigned PIN_PLLD   = 4;
   localparam logic [4:0]  PIN_RST    = 5'h0E;

   typedef enum logic [2:0] {
      SCH_CFG_DEVICE,
      SCH_PASSIVE_SERIAL,
      SCH_PARALLEL_ASYNC,
      SCH_FAST_PARALLEL,
      SCH_BOUNDARY_SCAN
   } fcms_scheme_type;

   typedef enum logic [2:0] {
      ST_POR,
      ST_WAIT_CE,
      ST_LOAD,
      ST_INIT,
      ST_USER
   } fcms_state_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } fcms_aphase_type;

   function automatic logic fcms_hit(input fcms_aphase_type a, input logic [7:0] ofs);
      return a.valid && (a.addr == ofs);
   endfunction : fcms_hit
endpackage : fcms_pkg
